// >>> bench/tb_pmd_bank.sv
// self-checking bench for the module-disable register bank
`timescale 1ns/1ps
module tb_pmd_bank;
  import pmd_bank_pkg::*;
  // ----------------------------------------------------------------
  // stimulus signals and expectation store
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic t_off, q_off, p_off, w_off, a_off, s_off, c_off, r_off;
  logic [3:0] cc_off;
  logic [3:0] lc_off;
  logic [1:0] dma_off;
  logic [2:0] cmp_off;
  logic [2:0] amp_off;
  logic [15:0] ce1, ce2, ce4, ce6, ce7, ce8;
  // each note: {compare data, expected error, expected data}
  logic [33:0] notes[$];
  logic [33:0] e;
  logic [15:0] model[7];
  logic [11:0] ofs[7] = '{OFS_LOCK, OFS_ONE, OFS_TWO, OFS_FOUR, OFS_SIX, OFS_SEVEN, OFS_EIGHT};
  logic [15:0] msk[7] = '{MASK_LOCK, MASK_ONE, MASK_TWO, MASK_FOUR, MASK_SIX, MASK_SEVEN,
                          MASK_EIGHT};
  logic [15:0] d;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  always #2 sys_clk = ~sys_clk;

  pmd_bank dut_u (
    .SYS_CLK(sys_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER_OFF(t_off), .QUAD_ENCODER_OFF(q_off), .PULSE_WIDTH_OFF(p_off),
    .TWO_WIRE_OFF(w_off), .ASYNC_SERIAL_OFF(a_off), .SYNC_SERIAL_OFF(s_off),
    .CONVERTER_OFF(c_off), .CAPCOMP_OFF(cc_off), .REFCLK_OUT_OFF(r_off),
    .DMA_CHAN_OFF(dma_off), .COMPARATOR_OFF(cmp_off), .GAIN_AMP_OFF(amp_off),
    .LOGIC_CELL_OFF(lc_off), .CLK_ENABLE_ONE(ce1), .CLK_ENABLE_TWO(ce2),
    .CLK_ENABLE_FOUR(ce4), .CLK_ENABLE_SIX(ce6), .CLK_ENABLE_SEVEN(ce7),
    .CLK_ENABLE_EIGHT(ce8)
  );

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : cmp

  // request stays up after the answer so back-to-back setups need no extra edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat,
                     input logic [3:0] st, input logic err, input logic chkd);
    int n;
    n = 0;
    notes.push_back({chkd, err, chkd ? dat : 32'h0000_0000});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? dat : 32'h0000_0000;
    pstrb <= st;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) cmp(1, 0, "no bus answer");
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : idle

  task automatic rd(input int i);
    apb(1'b0, ofs[i], {16'h0000, model[i]}, 4'hF, 1'b0, 1'b1);
  endtask : rd

  // lock register is writable whatever the lock bit; a refused write leaves the model untouched
  task automatic wr(input int i, input logic [15:0] v, input logic [3:0] st);
    logic ok;
    ok = (i == 0 || model[0][B_PERMIT]) && st[1:0] == 2'b11;
    if (ok) model[i] = v & msk[i];
    apb(1'b1, ofs[i], {16'h0000, v}, st, !ok, 1'b0);
  endtask : wr

  task automatic check_outs();
    idle();
    repeat (2) @(posedge sys_clk);
    #1;
    cmp({t_off, q_off, p_off, w_off, a_off, s_off, c_off, cc_off, r_off, dma_off, cmp_off,
         amp_off, lc_off},
        {model[1][11], model[1][10], model[1][9], model[1][7], model[1][5], model[1][3],
         model[1][0], model[2][3:0], model[3][3], model[4][9:8], model[5][10:8],
         model[6][14], model[6][10], model[5][1], model[6][5:2]}, "disable outputs");
    cmp({ce1, ce2, ce4, ce6, ce7, ce8},
        {msk[1] & ~model[1], msk[2] & ~model[2], msk[3] & ~model[3], msk[4] & ~model[4],
         msk[5] & ~model[5], msk[6] & ~model[6]}, "clock enables");
    @(posedge sys_clk);
  endtask : check_outs

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // answers are matched to notes in issue order
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) cmp(1, 0, "unexpected answer");
      else begin
        e = notes.pop_front();
        cmp(pslverr, e[32], "error response");
        if (e[33]) cmp(prdata, e[31:0], "read data");
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR %0t run exceeded cycle ceiling", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hE44F));
    for (int i = 0; i < 7; i++) model[i] = 16'h0000;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    check_outs();
    for (int i = 0; i < 7; i++) rd(i);
    $display("test done: reset values");
    for (int i = 1; i < 7; i++) wr(i, 16'hFFFF, 4'hF);
    for (int i = 1; i < 7; i++) rd(i);
    check_outs();
    $display("test done: locked writes");
    wr(0, 16'hFFFF, 4'hF);
    for (int i = 1; i < 7; i++) wr(i, 16'hFFFF, 4'hF);
    for (int i = 0; i < 7; i++) rd(i);
    check_outs();
    $display("test done: all ones");
    // walking ones then random words catch swapped or stuck fields
    for (int k = 0; k < 28; k++) begin
      for (int i = 1; i < 7; i++) begin
        d = (k < 16) ? (16'h0001 << k) : 16'($urandom());
        wr(i, d, 4'hF);
      end
      for (int i = 0; i < 7; i++) rd(i);
      check_outs();
    end
    $display("test done: walking and random");
    // refused strobes and unmapped addresses
    wr(1, ~model[1], 4'h1);
    apb(1'b0, 12'h01C, 32'h0000_0000, 4'hF, 1'b1, 1'b1);
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, 4'hF, 1'b1, 1'b0);
    for (int i = 0; i < 7; i++) rd(i);
    check_outs();
    $display("test done: refusals");
    wr(0, 16'h0000, 4'hF);
    for (int i = 1; i < 7; i++) wr(i, ~model[i], 4'hF);
    for (int i = 0; i < 7; i++) rd(i);
    check_outs();
    $display("test done: relock");
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 7; i++) model[i] = 16'h0000;
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) rd(i);
    check_outs();
    $display("test done: second reset");
    give_verdict();
  end
endmodule : tb_pmd_bank

// >>> logic/pmd_bank.sv
// module-disable register bank on APB, with per-peripheral off and clock-gate enables
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module pmd_bank (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic TIMER_OFF,
  output logic QUAD_ENCODER_OFF,
  output logic PULSE_WIDTH_OFF,
  output logic TWO_WIRE_OFF,
  output logic ASYNC_SERIAL_OFF,
  output logic SYNC_SERIAL_OFF,
  output logic CONVERTER_OFF,
  output logic [3:0] CAPCOMP_OFF,
  output logic REFCLK_OUT_OFF,
  output logic [1:0] DMA_CHAN_OFF,
  output logic [2:0] COMPARATOR_OFF,
  output logic [2:0] GAIN_AMP_OFF,
  output logic [3:0] LOGIC_CELL_OFF,
  output logic [15:0] CLK_ENABLE_ONE,
  output logic [15:0] CLK_ENABLE_TWO,
  output logic [15:0] CLK_ENABLE_FOUR,
  output logic [15:0] CLK_ENABLE_SIX,
  output logic [15:0] CLK_ENABLE_SEVEN,
  output logic [15:0] CLK_ENABLE_EIGHT
);
  import pmd_bank_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [15:0] regs [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0] wr_en;
  logic access;
  logic wr_access;
  logic mapped;
  logic permit;
  logic lanes_ok;
  logic [15:0] wdata16;
  logic [15:0] rsel;
  logic [2:0] ridx;
  logic setup;
  logic pready_q;

  // the answer is built during setup, so pready, data and error all stand together
  assign setup = PSEL & ~PENABLE;
  // a write lands only at the edge where pready is sampled high
  assign access = PSEL & PENABLE & pready_q;
  assign wr_access = access & PWRITE;
  assign hit[IDX_LOCK] = (PADDR == OFS_LOCK);
  assign hit[IDX_ONE] = (PADDR == OFS_ONE);
  assign hit[IDX_TWO] = (PADDR == OFS_TWO);
  assign hit[IDX_FOUR] = (PADDR == OFS_FOUR);
  assign hit[IDX_SIX] = (PADDR == OFS_SIX);
  assign hit[IDX_SEVEN] = (PADDR == OFS_SEVEN);
  assign hit[IDX_EIGHT] = (PADDR == OFS_EIGHT);
  assign mapped = |hit;
  // a partial write to a 16-bit register is refused rather than half applied
  assign lanes_ok = (PSTRB[1:0] == 2'h3);
  assign wdata16 = PWDATA[15:0];

  // RULE15: permit gate
  // the lock register itself stays writable, otherwise it could never be opened
  assign permit = regs[IDX_LOCK][B_PERMIT];

  assign wr_en[IDX_LOCK] = wr_access & hit[IDX_LOCK] & lanes_ok;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  localparam logic [15:0] MASKS [NUM_REGS] = '{MASK_LOCK, MASK_ONE, MASK_TWO, MASK_FOUR,
                                               MASK_SIX, MASK_SEVEN, MASK_EIGHT};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      if (gi != IDX_LOCK) begin : g_wr
        // RULE15: refused while locked
        assign wr_en[gi] = wr_access & hit[gi] & lanes_ok & permit;
      end
      // RULE13: masked storage
      // RULE14: reset to zero
      pmd_reg_cell #(
        .MASK(MASKS[gi]),
        .RESET(RST_VAL)
      ) u_cell (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .wr_en(wr_en[gi]),
        .wr_data(wdata16),
        .value(regs[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign ridx = hit[IDX_ONE] ? IDX_ONE :
                hit[IDX_TWO] ? IDX_TWO :
                hit[IDX_FOUR] ? IDX_FOUR :
                hit[IDX_SIX] ? IDX_SIX :
                hit[IDX_SEVEN] ? IDX_SEVEN :
                hit[IDX_EIGHT] ? IDX_EIGHT : IDX_LOCK;
  // RULE13: zero above and in unimplemented bits
  assign rsel = mapped ? regs[ridx] : RST_VAL;

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  assign prdata_d = (setup & ~PWRITE) ? {16'h0000, rsel} : ZERO_WORD;
  // errors: unmapped address, or a write that the lock or lanes refuse
  assign pslverr_d = setup & (~mapped |
                     (PWRITE & ~lanes_ok) |
                     (PWRITE & ~hit[IDX_LOCK] & ~permit));

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q <= ZERO_WORD;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // registered answers are ready in the first access cycle, no wait state
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  // ----------------------------------------------------------------
  // disable outputs
  // ----------------------------------------------------------------
  logic [15:0] one_v;
  logic [15:0] two_v;
  logic [15:0] four_v;
  logic [15:0] six_v;
  logic [15:0] seven_v;
  logic [15:0] eight_v;

  assign one_v = regs[IDX_ONE];
  assign two_v = regs[IDX_TWO];
  assign four_v = regs[IDX_FOUR];
  assign six_v = regs[IDX_SIX];
  assign seven_v = regs[IDX_SEVEN];
  assign eight_v = regs[IDX_EIGHT];

  logic timer_off_q;
  logic quad_encoder_off_q;
  logic pulse_width_off_q;
  logic two_wire_off_q;
  logic async_serial_off_q;
  logic sync_serial_off_q;
  logic converter_off_q;
  logic [3:0] capcomp_off_q;
  logic refclk_out_off_q;
  logic [1:0] dma_chan_off_q;
  logic [2:0] comparator_off_q;
  logic [2:0] gain_amp_off_q;
  logic [3:0] logic_cell_off_q;
  logic [15:0] clk_en_q [6];

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_off_q <= 1'b0;
      quad_encoder_off_q <= 1'b0;
      pulse_width_off_q <= 1'b0;
      two_wire_off_q <= 1'b0;
      async_serial_off_q <= 1'b0;
      sync_serial_off_q <= 1'b0;
      converter_off_q <= 1'b0;
      refclk_out_off_q <= 1'b0;
    end else begin
      // RULE1: timer off
      timer_off_q <= one_v[B_TIMER];
      // RULE2: encoder off
      quad_encoder_off_q <= one_v[B_QUAD];
      // RULE3: pwm off
      pulse_width_off_q <= one_v[B_PWM];
      // RULE4: serial modules off
      two_wire_off_q <= one_v[B_TWO_WIRE];
      async_serial_off_q <= one_v[B_ASYNC];
      sync_serial_off_q <= one_v[B_SYNC];
      // RULE5: converter off
      converter_off_q <= one_v[B_CONV];
      // RULE7: refclk output off
      refclk_out_off_q <= four_v[B_REFCLK];
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      capcomp_off_q <= 4'h0;
      dma_chan_off_q <= 2'h0;
      comparator_off_q <= 3'h0;
      gain_amp_off_q <= 3'h0;
      logic_cell_off_q <= 4'h0;
    end else begin
      // RULE6: capture/compare units off
      capcomp_off_q <= two_v[B_CAPCOMP_LO +: N_CAPCOMP];
      // RULE8: dma channels off
      dma_chan_off_q <= six_v[B_DMA_LO +: N_DMA];
      // RULE9: comparators off
      comparator_off_q <= seven_v[B_CMP_LO +: N_CMP];
      // RULE10: amplifier one
      // RULE11: amplifiers two and three
      gain_amp_off_q <= {eight_v[B_GAIN_THREE], eight_v[B_GAIN_TWO], seven_v[B_GAIN_ONE]};
      // RULE12: logic cells off
      logic_cell_off_q <= eight_v[B_CELL_LO +: N_CELL];
    end
  end

  // RULE16: clock enables gate off disabled peripherals
  // clock enable per bit: implemented bit and not disabled; unused bits stay low
  generate
    for (gi = 1; gi < NUM_REGS; gi++) begin : g_clken
      logic [15:0] en_q;
      always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          en_q <= MASKS[gi];
        end else begin
          en_q <= MASKS[gi] & ~regs[gi];
        end
      end
      assign clk_en_q[gi-1] = en_q;
    end
  endgenerate

  assign TIMER_OFF = timer_off_q;
  assign QUAD_ENCODER_OFF = quad_encoder_off_q;
  assign PULSE_WIDTH_OFF = pulse_width_off_q;
  assign TWO_WIRE_OFF = two_wire_off_q;
  assign ASYNC_SERIAL_OFF = async_serial_off_q;
  assign SYNC_SERIAL_OFF = sync_serial_off_q;
  assign CONVERTER_OFF = converter_off_q;
  assign CAPCOMP_OFF = capcomp_off_q;
  assign REFCLK_OUT_OFF = refclk_out_off_q;
  assign DMA_CHAN_OFF = dma_chan_off_q;
  assign COMPARATOR_OFF = comparator_off_q;
  assign GAIN_AMP_OFF = gain_amp_off_q;
  assign LOGIC_CELL_OFF = logic_cell_off_q;
  assign CLK_ENABLE_ONE = clk_en_q[0];
  assign CLK_ENABLE_TWO = clk_en_q[1];
  assign CLK_ENABLE_FOUR = clk_en_q[2];
  assign CLK_ENABLE_SIX = clk_en_q[3];
  assign CLK_ENABLE_SEVEN = clk_en_q[4];
  assign CLK_ENABLE_EIGHT = clk_en_q[5];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_locked_write_refused: assert property ( // RULE15
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (wr_access & hit[IDX_ONE] & ~permit) |=> (regs[IDX_ONE] == $past(regs[IDX_ONE])))
    else $error("disable one changed while locked");

  chk_one_unimpl_zero: assert property ( // RULE13
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (regs[IDX_ONE] & ~MASK_ONE) == RST_VAL)
    else $error("unimplemented bit set in disable one");

  chk_timer_follows: assert property ( // RULE1
    @(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(one_v[B_TIMER]) |=> TIMER_OFF)
    else $error("timer off did not follow its bit");

  chk_cell_follows: assert property ( // RULE12
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (LOGIC_CELL_OFF == $past(eight_v[B_CELL_LO +: N_CELL])))
    else $error("logic cell off mismatch");

  chk_permitted_write: assert property ( // RULE14
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (wr_access & hit[IDX_TWO] & permit & lanes_ok) |=> (regs[IDX_TWO] == ($past(wdata16) & MASK_TWO)))
    else $error("permitted write not stored");

  chk_gain_map: assert property ( // RULE11
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (GAIN_AMP_OFF[2] == $past(eight_v[B_GAIN_THREE]) &&
              GAIN_AMP_OFF[1] == $past(eight_v[B_GAIN_TWO]) &&
              GAIN_AMP_OFF[0] == $past(seven_v[B_GAIN_ONE])))
    else $error("amplifier off mismatch");

  chk_clock_gated: assert property ( // RULE16
    @(posedge SYS_CLK) disable iff (!ARST_N)
    TIMER_OFF |-> !CLK_ENABLE_ONE[B_TIMER])
    else $error("clock enabled on disabled timer");

  chk_dma_follows: assert property ( // RULE8
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (DMA_CHAN_OFF == $past(six_v[B_DMA_LO +: N_DMA])))
    else $error("dma off mismatch");

  chk_read_data: assert property ( // RULE14
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (setup & ~PWRITE & hit[IDX_ONE]) |=> (PRDATA == {RST_VAL, $past(regs[IDX_ONE])}))
    else $error("read data of disable one wrong");

  chk_unmapped_error: assert property ( // RULE13
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (setup & ~mapped) |=> (PSLVERR && PRDATA == ZERO_WORD))
    else $error("unmapped access not refused");

  chk_lock_error: assert property ( // RULE15
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (setup & PWRITE & mapped & ~hit[IDX_LOCK] & ~permit) |=> PSLVERR)
    else $error("locked write not flagged");

  chk_encoder_follows: assert property ( // RULE2
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (QUAD_ENCODER_OFF == $past(one_v[B_QUAD])))
    else $error("encoder off mismatch");

  chk_serial_follows: assert property ( // RULE4
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> ({TWO_WIRE_OFF, ASYNC_SERIAL_OFF, SYNC_SERIAL_OFF} ==
              $past({one_v[B_TWO_WIRE], one_v[B_ASYNC], one_v[B_SYNC]})))
    else $error("serial off mismatch");

  chk_capcomp_follows: assert property ( // RULE6
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (CAPCOMP_OFF == $past(two_v[B_CAPCOMP_LO +: N_CAPCOMP])))
    else $error("capture compare off mismatch");

  chk_refclk_follows: assert property ( // RULE7
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (REFCLK_OUT_OFF == $past(four_v[B_REFCLK])))
    else $error("refclk off mismatch");

  chk_comparator_follows: assert property ( // RULE9
    @(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> (COMPARATOR_OFF == $past(seven_v[B_CMP_LO +: N_CMP])))
    else $error("comparator off mismatch");

endmodule : pmd_bank

// >>> logic/pmd_bank_pkg.sv
// package: register map, field positions and reset values of the module-disable bank
// Summary of operation
// RULE1: timer_off, bit 11 of disable one, switches the timer off when set.
// RULE2: quad_encoder_off, bit 10 of disable one, switches the encoder off when set.
// RULE3: pulse_width_off, bit 9 of disable one, switches the PWM off when set.
// RULE4: bits 7, 5, 3 of disable one switch off two-wire, async, sync serial.
// RULE5: converter_off, bit 0 of disable one, switches the converter off when set.
// RULE6: disable two bits 3..0 switch off capture/compare units four..one.
// RULE7: refclk_out_off, bit 3 of disable four, switches reference clock output off.
// RULE8: disable six bits 9 and 8 switch off DMA channels one and zero.
// RULE9: disable seven bits 10..8 switch off comparators three..one.
// RULE10: gain_amp_one_off, bit 1 of disable seven, switches amplifier one off.
// RULE11: disable eight bit 14 and bit 10 switch off amplifiers three and two.
// RULE12: disable eight bits 5..2 switch off logic cells four..one.
// RULE13: unimplemented bits read zero and ignore writes.
// RULE14: implemented bits are read/write and clear to zero at reset.
// RULE15: disable bits are writable only while lock register bit 11 is one.
// RULE16: a disabled peripheral has its clock gated and is held inactive.
package pmd_bank_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_LOCK = 12'h000;
  localparam logic [11:0] OFS_ONE = 12'h004;
  localparam logic [11:0] OFS_TWO = 12'h008;
  localparam logic [11:0] OFS_FOUR = 12'h00C;
  localparam logic [11:0] OFS_SIX = 12'h010;
  localparam logic [11:0] OFS_SEVEN = 12'h014;
  localparam logic [11:0] OFS_EIGHT = 12'h018;

  localparam int REG_W = 16;
  localparam int NUM_REGS = 7;
  localparam int IDX_W = 3;

  // register indices inside the bank
  localparam logic [2:0] IDX_LOCK = 3'h0;
  localparam logic [2:0] IDX_ONE = 3'h1;
  localparam logic [2:0] IDX_TWO = 3'h2;
  localparam logic [2:0] IDX_FOUR = 3'h3;
  localparam logic [2:0] IDX_SIX = 3'h4;
  localparam logic [2:0] IDX_SEVEN = 3'h5;
  localparam logic [2:0] IDX_EIGHT = 3'h6;

  // ----------------------------------------------------------------
  // implemented-bit masks and reset value
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_LOCK = 16'h0800;
  localparam logic [15:0] MASK_ONE = 16'h0EA9;
  localparam logic [15:0] MASK_TWO = 16'h000F;
  localparam logic [15:0] MASK_FOUR = 16'h0008;
  localparam logic [15:0] MASK_SIX = 16'h0300;
  localparam logic [15:0] MASK_SEVEN = 16'h0702;
  localparam logic [15:0] MASK_EIGHT = 16'h443C;
  localparam logic [15:0] RST_VAL = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_PERMIT = 11;
  localparam int B_TIMER = 11;
  localparam int B_QUAD = 10;
  localparam int B_PWM = 9;
  localparam int B_TWO_WIRE = 7;
  localparam int B_ASYNC = 5;
  localparam int B_SYNC = 3;
  localparam int B_CONV = 0;
  localparam int B_CAPCOMP_LO = 0;
  localparam int B_REFCLK = 3;
  localparam int B_DMA_LO = 8;
  localparam int B_CMP_LO = 8;
  localparam int B_GAIN_ONE = 1;
  localparam int B_GAIN_TWO = 10;
  localparam int B_GAIN_THREE = 14;
  localparam int B_CELL_LO = 2;

  localparam int N_CAPCOMP = 4;
  localparam int N_DMA = 2;
  localparam int N_CMP = 3;
  localparam int N_CELL = 4;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage : pmd_bank_pkg

// >>> logic/pmd_reg_cell.sv
// one masked control register with a write-enable input
`timescale 1ns/1ps
module pmd_reg_cell #(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RESET = 16'h0000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value
);

  logic [15:0] value_q;
  logic [15:0] value_d;

  // unimplemented positions never take a write
  assign value_d = (wr_data & MASK) | (value_q & ~MASK);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= RESET & MASK;
    end else if (wr_en) begin
      value_q <= value_d & MASK;
    end
  end

  assign value = value_q;

endmodule : pmd_reg_cell
